// file: gcm_clock_mux.sv
// Glitch-free two-source clock selector driving ten output pairs
//
// Overview of operation
// - Every output pair is derived from the two input pairs and the select, one source at a time, gated by the enable.
// - The selected clock is copied onto ten identical output pairs.
// - A source change never produces a shortened high phase, low phase or runt pulse.
// - A selected input that loses its swing leaves the outputs parked low, as does one that stops toggling unless the timing pin is tied.
// - An open select pin counts as logic high.
// - The enable gates all ten pairs together, disabled pairs show true low and complement high.
// - Enable changes take effect only while the output is low, so no runt is produced.
// - An open enable pin counts as logic high.
// - A power-on timer holds the switchover logic in a known state before it operates.
// - With the timing pin tied to the supply, runt suppression is bypassed for a plain multiplexer.
`timescale 1ns/100ps
module gcm_clock_mux
  import gcm_pkg::*;
#(
  parameter int unsigned DEAD_LIMIT = DEAD_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Clock sources, sampled as levels
  input wire gcm_diff_t primary_clk_in,
  input wire gcm_diff_t alternate_clk_in,
  // Source select and its open-pin indication
  input wire logic src_sel_in,
  input wire logic src_sel_open_in,
  // Output enable and its open-pin indication
  input wire logic out_en_in,
  input wire logic out_en_open_in,
  // Timing pin tied to the supply
  input wire logic por_timing_pin_tied_in,
  // Fanout outputs
  output logic [FANOUT_COUNT-1:0] fanout_outputs_true_out,
  output logic [FANOUT_COUNT-1:0] fanout_outputs_comp_out
);
  // ==========================================================
  // Helpers
  function automatic logic pick_true(input logic src, input gcm_diff_t p, input gcm_diff_t a);
    pick_true = (src == SRC_ALTERNATE) ? a.tru : p.tru;
  endfunction

  function automatic logic has_swing(input logic src, input gcm_diff_t p, input gcm_diff_t a);
    has_swing = (src == SRC_ALTERNATE) ? (a.tru ^ a.comp) : (p.tru ^ p.comp);
  endfunction

  logic sel_eff;
  logic en_eff;
  assign sel_eff = src_sel_in | src_sel_open_in;
  assign en_eff = out_en_in | out_en_open_in;

  // ==========================================================
  // State
  gcm_state_t state_q, state_d;
  logic cur_src_q, cur_src_d;
  logic mux_q, mux_d;
  logic en_act_q, en_act_d;
  logic last_raw_q, last_raw_d;
  logic dead_q, dead_d;
  logic [CNT_W-1:0] idle_q, idle_d;
  logic [CNT_W-1:0] por_cnt_q, por_cnt_d;
  logic por_done_q, por_done_d;
  logic armed_q, armed_d;
  logic [FANOUT_COUNT-1:0] true_q, true_d;
  logic [FANOUT_COUNT-1:0] comp_q, comp_d;

  logic raw;
  logic live;
  assign raw = pick_true(cur_src_q, primary_clk_in, alternate_clk_in);
  assign live = has_swing(cur_src_q, primary_clk_in, alternate_clk_in) & ~dead_q;

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    cur_src_d = cur_src_q;
    mux_d = mux_q;
    en_act_d = en_act_q;
    last_raw_d = raw;
    dead_d = dead_q;
    idle_d = idle_q;
    por_cnt_d = por_cnt_q;
    por_done_d = por_done_q;
    armed_d = armed_q;
    // Dead input watch: a level that never changes parks the output
    if (raw != last_raw_q) begin
      idle_d = '0;
      dead_d = 1'b0;
    end else if (idle_q >= CNT_W'(DEAD_LIMIT - 1)) begin
      dead_d = 1'b1;
    end else begin
      idle_d = idle_q + CNT_W'(1);
    end
    if (por_timing_pin_tied_in) begin
      // Plain multiplexer, accepts any glitch the select makes
      state_d = ST_FOLLOW;
      cur_src_d = sel_eff;
      mux_d = pick_true(sel_eff, primary_clk_in, alternate_clk_in) &
              has_swing(sel_eff, primary_clk_in, alternate_clk_in);
    end else if (!por_done_q) begin
      // Known start: output low, source taken from the select
      state_d = ST_FOLLOW;
      cur_src_d = sel_eff;
      mux_d = RST_MUX;
      if (por_cnt_q >= CNT_W'(POR_CYCLES - 1)) begin
        por_done_d = 1'b1;
      end else begin
        por_cnt_d = por_cnt_q + CNT_W'(1);
      end
    end else begin
      case (state_q)
        ST_FOLLOW: begin
          mux_d = raw & live;
          if (sel_eff != cur_src_q) begin
            state_d = ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          // Let the old high phase finish before leaving the source
          if (!mux_q) begin
            cur_src_d = sel_eff;
            state_d = ST_WAIT_LOW;
            armed_d = 1'b0;
            mux_d = 1'b0;
          end else begin
            mux_d = raw & live;
          end
        end
        ST_WAIT_LOW: begin
          // Join only after a falling edge of the new source, so its low and high are whole
          mux_d = 1'b0;
          if (sel_eff != cur_src_q) begin
            // Select moved again while parked low, retarget so a dead source cannot trap us
            cur_src_d = sel_eff;
            armed_d = 1'b0;
          end else if (raw) begin
            armed_d = 1'b1;
          end else if (armed_q) begin
            state_d = ST_FOLLOW;
          end
        end
        default: begin
          state_d = ST_FOLLOW;
          mux_d = 1'b0;
        end
      endcase
    end
    if (cur_src_d != cur_src_q) begin
      idle_d = '0;
      dead_d = 1'b0;
    end
    // Enable moves only while the output is low
    if (!mux_d) begin
      en_act_d = en_eff;
    end
    true_d = {FANOUT_COUNT{mux_d & en_act_d}};
    comp_d = ~true_d;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= ST_FOLLOW;
      cur_src_q <= SRC_ALTERNATE;
      mux_q <= RST_MUX;
      en_act_q <= RST_EN;
      last_raw_q <= 1'b0;
      dead_q <= 1'b0;
      idle_q <= '0;
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
      armed_q <= 1'b0;
      true_q <= '0;
      comp_q <= '1;
    end else begin
      state_q <= state_d;
      cur_src_q <= cur_src_d;
      mux_q <= mux_d;
      en_act_q <= en_act_d;
      last_raw_q <= last_raw_d;
      dead_q <= dead_d;
      idle_q <= idle_d;
      por_cnt_q <= por_cnt_d;
      por_done_q <= por_done_d;
      armed_q <= armed_d;
      true_q <= true_d;
      comp_q <= comp_d;
    end
  end

  assign fanout_outputs_true_out = true_q;
  assign fanout_outputs_comp_out = comp_q;

  // ==========================================================
  // Checks
  copies_equal_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    true_q == {FANOUT_COUNT{true_q[0]}}) else $error("fanout copies differ");

  pair_complement_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    comp_q == ~true_q) else $error("complement output not inverted");

  enable_low_only_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(en_act_q) |-> !mux_q) else $error("enable changed during high output");

  disabled_parks_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !en_act_q |-> true_q == '0) else $error("disabled output toggled");

  open_select_high_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (por_done_q && src_sel_open_in && state_q == ST_FOLLOW && !por_timing_pin_tied_in)
    |=> ##[0:2] (state_q != ST_FOLLOW || cur_src_q == SRC_ALTERNATE))
    else $error("open select not treated as high");

  no_runt_high_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == ST_WAIT_LOW && !por_timing_pin_tied_in) |-> !mux_q)
    else $error("output high while joining new source");

  por_holds_low_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!por_done_q && !por_timing_pin_tied_in) |=> !mux_q)
    else $error("output active before power-on timer");

  follow_primary_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (por_done_q && state_q == ST_FOLLOW && cur_src_q == SRC_PRIMARY && !dead_q &&
     !por_timing_pin_tied_in && (primary_clk_in.tru ^ primary_clk_in.comp))
    |=> mux_q == $past(primary_clk_in.tru)) else $error("primary not followed");

  dead_parks_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (dead_q && !por_timing_pin_tied_in && state_q != ST_DRAIN) |=> !mux_q)
    else $error("dead input not parked");

  bypass_mux_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    por_timing_pin_tied_in |=> mux_q == ($past(sel_eff) ?
      $past(alternate_clk_in.tru & (alternate_clk_in.tru ^ alternate_clk_in.comp)) :
      $past(primary_clk_in.tru & (primary_clk_in.tru ^ primary_clk_in.comp))))
    else $error("bypass not a plain multiplexer");
endmodule

// file: gcm_pkg.sv
// Package for the glitch-free clock selector with ten-way fanout
package gcm_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POR_TIME_NS = 10000;
  localparam int unsigned POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
  // Slowest supported source is 1 kHz, so a half period is 500 us
  localparam int unsigned DEAD_TIME_NS = 500000;
  localparam int unsigned DEAD_CYCLES = DEAD_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FANOUT_COUNT = 10;
  localparam int unsigned CNT_W = 20;
  // ==========================================================
  // Values after reset
  localparam logic SRC_PRIMARY = 1'h0;
  localparam logic SRC_ALTERNATE = 1'h1;
  localparam logic RST_MUX = 1'h0;
  localparam logic RST_EN = 1'h1;
  // ==========================================================
  // Types
  typedef struct packed {
    logic tru;
    logic comp;
  } gcm_diff_t;

  typedef enum logic [2:0] {
    ST_FOLLOW = 3'h1,
    ST_DRAIN = 3'h2,
    ST_WAIT_LOW = 3'h4
  } gcm_state_t;
endpackage

// file: gcm_src_model.sv
// Partner model: two source clocks with settable half periods and failure modes
`timescale 1ns/100ps
module gcm_src_model
  import gcm_pkg::*;
(
  // Clock and controls
  input wire logic mclk_in,
  input wire logic [3:0] half_a_in,
  input wire logic [3:0] half_b_in,
  input wire logic stop_a_in,
  input wire logic flat_b_in,
  // Source pairs
  output gcm_diff_t primary_out,
  output gcm_diff_t alternate_out
);
  int cnt_a = 0;
  int cnt_b = 0;
  logic lvl_a = 1'h0;
  logic lvl_b = 1'h0;
  // ==========================================================
  // Sources
  always @(posedge mclk_in) begin
    cnt_a <= (cnt_a + 1 >= half_a_in) ? 0 : cnt_a + 1;
    cnt_b <= (cnt_b + 1 >= half_b_in) ? 0 : cnt_b + 1;
    // A stopped source settles to a static level, as a failed clock does
    if (!stop_a_in && cnt_a + 1 >= half_a_in) begin
      lvl_a <= ~lvl_a;
    end
    if (cnt_b + 1 >= half_b_in) begin
      lvl_b <= ~lvl_b;
    end
  end
  assign primary_out = '{tru: lvl_a, comp: ~lvl_a};
  // Flat pair carries no differential swing
  assign alternate_out = '{tru: lvl_b, comp: flat_b_in ? lvl_b : ~lvl_b};
endmodule

// file: tb_glitch_free_clock_mux_fanout.sv
// Testbench for the glitch-free clock selector with ten-way fanout
`timescale 1ns/100ps
module tb_glitch_free_clock_mux_fanout;
  import gcm_pkg::*;
  // ==========================================================
  // Signals
  logic mclk_in = 1'h0;
  logic rst_in = 1'h1;
  logic sel = 1'h0;
  logic sel_open = 1'h0;
  logic en = 1'h1;
  logic en_open = 1'h0;
  logic tied = 1'h0;
  logic stop_a = 1'h0;
  logic flat_b = 1'h0;
  logic [3:0] ha = 4'h3;
  logic [3:0] hb = 4'h4;
  gcm_diff_t pri;
  gcm_diff_t alt;
  gcm_diff_t s;
  logic [FANOUT_COUNT-1:0] t_out;
  logic [FANOUT_COUNT-1:0] c_out;
  logic exp_q = 1'h0;
  logic track = 1'h0;
  logic run_chk = 1'h0;
  logic last = 1'h0;
  int run = 0;
  int fail_count = 0;
  int n_compared = 0;
  always #5 mclk_in = ~mclk_in;
  gcm_src_model gcm_src_model_i (.mclk_in(mclk_in), .half_a_in(ha), .half_b_in(hb),
    .stop_a_in(stop_a), .flat_b_in(flat_b), .primary_out(pri), .alternate_out(alt));
  gcm_clock_mux #(.DEAD_LIMIT(16)) gcm_clock_mux_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .primary_clk_in(pri), .alternate_clk_in(alt), .src_sel_in(sel),
    .src_sel_open_in(sel_open), .out_en_in(en), .out_en_open_in(en_open),
    .por_timing_pin_tied_in(tied), .fanout_outputs_true_out(t_out),
    .fanout_outputs_comp_out(c_out));
  // ==========================================================
  // Checking
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reference: selected true side, dead when swing is lost, one cycle late
  always @(posedge mclk_in) begin
    s = (sel | sel_open) ? alt : pri;
    exp_q <= s.tru & (s.tru != s.comp);
  end
  always @(negedge mclk_in) begin
    if (!rst_in) begin
      chk("comp", ~t_out, c_out);
      chk("copies", {FANOUT_COUNT{t_out[0]}}, t_out);
      if (track) chk("follow", {FANOUT_COUNT{exp_q}}, t_out);
      if (t_out[0] !== last) begin
        if (run_chk) chk("phase", 10'h1, {9'h0, run >= ha || run >= hb});
        run = 1;
        last = t_out[0];
      end else run++;
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    void'($urandom(75847));
    ha <= 4'h3 + 4'($urandom % 3);
    hb <= 4'h3 + 4'($urandom % 3);
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'h0;
    @(negedge mclk_in);
    chk("reset_out", '0, t_out);
    repeat (POR_CYCLES - 20) @(negedge mclk_in);
    chk("por_out", '0, t_out);
    repeat (40) @(posedge mclk_in);
    run_chk <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      track <= 1'h0;
      sel <= i[0];
      sel_open <= (i == 2);
      repeat (30) @(posedge mclk_in);
      track <= 1'h1;
      repeat (60) @(posedge mclk_in);
    end
    track <= 1'h0;
    repeat ($urandom % 8) @(posedge mclk_in);
    en <= 1'h0;
    repeat (30) @(negedge mclk_in);
    chk("disabled", '0, t_out);
    @(posedge mclk_in);
    en_open <= 1'h1;
    repeat (30) @(posedge mclk_in);
    track <= 1'h1;
    repeat (60) @(posedge mclk_in);
    track <= 1'h0;
    run_chk <= 1'h0;
    flat_b <= 1'h1;
    repeat (30) @(negedge mclk_in);
    chk("flat_parked", '0, t_out);
    @(posedge mclk_in);
    flat_b <= 1'h0;
    sel <= 1'h0;
    stop_a <= 1'h1;
    repeat (60) @(negedge mclk_in);
    chk("stop_parked", '0, t_out);
    @(posedge mclk_in);
    stop_a <= 1'h0;
    rst_in <= 1'h1;
    tied <= 1'h1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    track <= 1'h1;
    repeat (60) @(posedge mclk_in);
    complete_run;
  end
  // Watchdog: the sequence needs under 2000 cycles
  initial begin
    #50000;
    fail_count++;
    complete_run;
  end
endmodule
